// File: bench/adc_channel_gain_queue_ctrl_test.sv
// self-checking bench for the channel-gain queue controller
`include "adc_queue_regs.svh"
module adc_channel_gain_queue_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [5:0] ch; logic [2:0] rg; logic df; logic cm; logic [15:0] d;} row_t;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic conv_done_pin = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] conv_data = 16'h0000;
  logic [15:0] reg_rdata;
  logic [5:0] mux_chan;
  logic [1:0] gain_sel;
  logic unipolar, diff_mode, cm_ext_ref, conv_start_pulse;
  int num_errors = 0;
  int tests_run = 0;
  logic [15:0] s;
  row_t rows [8] = '{
    '{6'h3f, 3'h0, 1'b0, 1'b1, 16'hffff}, '{6'h1f, 3'h1, 1'b1, 1'b1, 16'h0000},
    '{6'h00, 3'h2, 1'b0, 1'b0, 16'h1234}, '{6'h05, 3'h3, 1'b1, 1'b0, 16'h8001},
    '{6'h20, 3'h4, 1'b0, 1'b0, 16'h7ffe}, '{6'h11, 3'h5, 1'b1, 1'b1, 16'h00ff},
    '{6'h2a, 3'h6, 1'b0, 1'b1, 16'ha5a5}, '{6'h01, 3'h7, 1'b1, 1'b0, 16'h5a5a}};

  adc_channel_gain_queue_ctrl uut (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mux_chan(mux_chan),
    .gain_sel(gain_sel), .unipolar(unipolar), .diff_mode(diff_mode),
    .cm_ext_ref(cm_ext_ref), .conv_start_pulse(conv_start_pulse),
    .conv_done_pin(conv_done_pin), .conv_data(conv_data)
  );

  always #50 core_clk = ~core_clk;

  task automatic stop_test;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one idle cycle after each strobe so a strobe is never set twice in a step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
    @(posedge core_clk);
  endtask

  // acquire, play the converter, wait for the stored sample, optionally pop it
  task automatic acq(input int i, input logic [15:0] d, input bit pop);
    int n;
    logic [15:0] q;
    reg_addr <= `ADDR_COMMAND;
    reg_wdata <= 16'h0004;
    reg_wr <= 1'b1;
    conv_data <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1 chk({10'h000, mux_chan}, {10'h000, rows[i].ch});
    chk({13'h0000, unipolar, gain_sel}, {13'h0000, rows[i].rg});
    chk({15'h0, diff_mode}, {15'h0, rows[i].df});
    chk({15'h0, cm_ext_ref}, {15'h0, rows[i].cm & ~rows[i].df});
    chk({15'h0, conv_start_pulse}, 16'h0001);
    @(posedge core_clk);
    conv_done_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
    conv_done_pin <= 1'b0;
    n = 0;
    do begin
      rd(`ADDR_STATUS, q);
      n++;
    end while ((q[`STAT_BUSY] !== 1'b0 || q[`STAT_READY] !== 1'b1) && n < 30);
    if (n >= 30) begin
      num_errors++;
      $display("[ERR] %0t sample never became ready", $time);
      stop_test();
    end
    if (pop) begin
      rd(`ADDR_SAMPLE, q);
      chk(q, d);
    end
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(`ADDR_STATUS, s);
    chk(s, 16'h0020);
    $display("reset test done");
    // scan list: every range code, both input kinds, both references
    wr(`ADDR_COMMAND, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      wr(`ADDR_QUEUE_ENTRY, {2'b00, rows[i].cm, rows[i].df, 1'b0, rows[i].rg, 2'b00, rows[i].ch});
    end
    rd(`ADDR_QUEUE_COUNT, s);
    chk(s, 16'h0008);
    wr(`ADDR_COMMAND, 16'h0002);
    rd(`ADDR_STATUS, s);
    chk(s, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      acq(i, rows[i].d, 1'b1);
    end
    acq(0, 16'h4321, 1'b1);
    $display("row test done");
    // entries after load done must be dropped
    wr(`ADDR_QUEUE_ENTRY, 16'h0003);
    rd(`ADDR_QUEUE_COUNT, s);
    chk(s, 16'h0008);
    $display("load done test done");
    // fill the sample fifo, pop half, then clear while it still holds data
    for (int k = 0; k < 8; k++) begin
      acq((k + 1) % 8, 16'h0100 + 16'(k), 1'b0);
    end
    rd(`ADDR_STATUS, s);
    chk({15'h0, s[`STAT_FULL]}, 16'h0001);
    for (int k = 0; k < 4; k++) begin
      rd(`ADDR_SAMPLE, s);
      chk(s, 16'h0100 + 16'(k));
    end
    wr(`ADDR_COMMAND, 16'h0008);
    rd(`ADDR_SAMPLE, s);
    chk(s, 16'h0000);
    rd(`ADDR_STATUS, s);
    chk({15'h0, s[`STAT_READY]}, 16'h0000);
    $display("fifo test done");
    // queue reset, then a differential entry above 31 is refused
    wr(`ADDR_COMMAND, 16'h0001);
    rd(`ADDR_QUEUE_COUNT, s);
    chk(s, 16'h0000);
    wr(`ADDR_QUEUE_ENTRY, 16'h1028);
    rd(`ADDR_QUEUE_COUNT, s);
    chk(s, 16'h0000);
    rd(`ADDR_STATUS, s);
    chk({15'h0, s[`STAT_BAD_ENTRY]}, 16'h0001);
    wr(`ADDR_QUEUE_ENTRY, 16'h0028);
    rd(`ADDR_QUEUE_COUNT, s);
    chk(s, 16'h0001);
    rd(4'hf, s);
    chk(s, 16'h0000);
    $display("refusal test done");
    // reset in mid-run wipes the list and the sticky refusal flag
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(`ADDR_STATUS, s);
    chk(s, 16'h0020);
    $display("mid-run reset test done");
    stop_test();
  end
endmodule

// File: bench/adc_queue_checker.sv
// port assertions for the channel-gain queue controller
`include "adc_queue_regs.svh"
module adc_queue_checker (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // front end
  input wire logic [5:0] mux_chan,
  input wire logic diff_mode,
  input wire logic cm_ext_ref,
  input wire logic conv_start_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence qreset_then_count;
    reg_wr && reg_addr == `ADDR_COMMAND && reg_wdata[`CMD_QUEUE_RESET]
      ##2 reg_rd && reg_addr == `ADDR_QUEUE_COUNT;
  endsequence
  sequence clear_then_sample;
    reg_wr && reg_addr == `ADDR_COMMAND && reg_wdata[`CMD_SAMPLE_CLEAR]
      ##2 reg_rd && reg_addr == `ADDR_SAMPLE;
  endsequence
  a_queue_reset_empty: assert property (qreset_then_count |=> reg_rdata == 16'h0000)
    else $error("queue count not zero after queue reset");
  a_sample_clear_empty: assert property (clear_then_sample |=> reg_rdata == 16'h0000)
    else $error("sample read not empty after clear");
  a_start_from_cmd: assert property ($rose(conv_start_pulse) |->
    $past(reg_wr && reg_addr == `ADDR_COMMAND && reg_wdata[`CMD_ACQUIRE]))
    else $error("conversion start without acquire command");
  a_start_one_cycle: assert property (conv_start_pulse |=> !conv_start_pulse)
    else $error("conversion start longer than one cycle");
  a_diff_chan_range: assert property (diff_mode |-> mux_chan <= 6'h1f)
    else $error("differential channel above 31");
  a_diff_ground_ref: assert property (diff_mode |-> !cm_ext_ref)
    else $error("external reference with differential input");
  a_front_end_hold: assert property (!conv_start_pulse |->
    $stable({mux_chan, diff_mode, cm_ext_ref}))
    else $error("front end changed outside an acquire");
  a_unmapped_zero: assert property (reg_rd && reg_addr > `ADDR_QUEUE_COUNT |=>
    reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule
bind adc_channel_gain_queue_ctrl adc_queue_checker chk (
  .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mux_chan(mux_chan),
  .diff_mode(diff_mode), .cm_ext_ref(cm_ext_ref), .conv_start_pulse(conv_start_pulse)
);

// File: logic/adc_channel_gain_queue_ctrl.sv
// channel-gain queue, software acquisition sequencer and sample path
// Notes on behaviour
// - queue reset command empties the channel-gain queue, ready for new entries
// - each entry write appends channel, range, diff and reference, in order
// - channels 0..63 single-ended, 0..31 differential; others are refused
// - range code picks gain 1,2,4,8; bit 2 selects unipolar spans
// - diff flag 0 single-ended, 1 differential for that conversion
// - single-ended reference: 0 system ground, 1 external common input
// - load-done stops entry acceptance and makes the list the active scan
// - acquire command starts one conversion; ready flag marks the result
// - conversions walk the entries in load order
// - results are 16-bit straight binary
// - sample clear command discards everything in the sample fifo
//
// The placing of the registers and strobed register access were left to the implementer.
`include "adc_queue_regs.svh"
module adc_channel_gain_queue_ctrl #(
  parameter int QUEUE_DEPTH = 64,
  parameter int FIFO_DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // analog front end control
  output logic [5:0] mux_chan,
  output logic [1:0] gain_sel,
  output logic unipolar,
  output logic diff_mode,
  output logic cm_ext_ref,
  output logic conv_start_pulse,
  // converter result
  input wire logic conv_done_pin,
  input wire logic [15:0] conv_data
);
  localparam int QW = $clog2(QUEUE_DEPTH);
  // the fill count and the scan pointer are sized from the queue depth
  if (QUEUE_DEPTH < 2 || QUEUE_DEPTH > 1024) begin : g_bad_queue_depth
    $error("queue depth out of range");
  end
  // the sample fifo wraps its pointers by bit width alone
  if (FIFO_DEPTH < 2 || (1 << $clog2(FIFO_DEPTH)) != FIFO_DEPTH) begin : g_bad_fifo_depth
    $error("fifo depth must be a power of two");
  end
  // reset release through two flops
  logic rst_meta_b;
  logic rst_sync_b;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end
  // converter done pin comes from outside: two-flop synchroniser
  logic done_meta;
  logic done_sync;
  logic done_prev;
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
      done_prev <= 1'b0;
    end else begin
      done_meta <= conv_done_pin;
      done_sync <= done_meta;
      done_prev <= done_sync;
    end
  end
  logic done_rise;
  assign done_rise = done_sync && !done_prev;

  function automatic logic entry_ok(input logic [15:0] w);
    // differential pairs only exist on the lower half of the inputs
    entry_ok = !(w[`ENT_DIFF] && w[`ENT_CHAN_MSB]);
  endfunction

  // one decoder for the command, entry and sample strobe and address pairs
  function automatic logic reg_hit(input logic strobe, input logic [3:0] addr,
    input logic [3:0] target);
    reg_hit = strobe && addr == target;
  endfunction

  logic cmd_wr;
  logic ent_wr;
  assign cmd_wr = reg_hit(reg_wr, reg_addr, `ADDR_COMMAND);
  assign ent_wr = reg_hit(reg_wr, reg_addr, `ADDR_QUEUE_ENTRY);
  logic cmd_qreset;
  logic cmd_done;
  logic cmd_acq;
  logic cmd_sclear;
  assign cmd_qreset = cmd_wr && reg_wdata[`CMD_QUEUE_RESET];
  assign cmd_done = cmd_wr && reg_wdata[`CMD_QUEUE_LOAD_DONE];
  assign cmd_acq = cmd_wr && reg_wdata[`CMD_ACQUIRE];
  assign cmd_sclear = cmd_wr && reg_wdata[`CMD_SAMPLE_CLEAR];

  // channel-gain queue storage
  adc_queue_pkg::queue_entry_t queue_mem [QUEUE_DEPTH];
  logic [QW:0] queue_len;
  logic [QW-1:0] scan_ptr;
  logic load_done;
  logic bad_entry;
  logic accept_entry;
  // a full queue drops further entries silently; the count read tells software
  assign accept_entry = ent_wr && !load_done && !cmd_qreset
    && queue_len != (QW+1)'(QUEUE_DEPTH) && entry_ok(reg_wdata);
  always_ff @(posedge core_clk) begin
    if (accept_entry) begin
      queue_mem[queue_len[QW-1:0]] <= '{cmref: reg_wdata[`ENT_CMREF],
        diff: reg_wdata[`ENT_DIFF], range: reg_wdata[`ENT_RANGE_MSB:`ENT_RANGE_LSB],
        chan: reg_wdata[`ENT_CHAN_MSB:`ENT_CHAN_LSB]};
    end
  end
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      queue_len <= '0;
    end else if (cmd_qreset) begin
      queue_len <= '0;
    end else if (accept_entry) begin
      queue_len <= queue_len + (QW+1)'(1);
    end
  end
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      load_done <= 1'b0;
    end else if (cmd_qreset) begin
      load_done <= 1'b0;
    end else if (cmd_done) begin
      load_done <= 1'b1;
    end
  end
  // sticky refusal flag, cleared by queue reset; a refusal in that cycle wins
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      bad_entry <= 1'b0;
    end else if (ent_wr && !load_done && !entry_ok(reg_wdata)) begin
      bad_entry <= 1'b1;
    end else if (cmd_qreset) begin
      bad_entry <= 1'b0;
    end
  end

  // conversion sequencer
  adc_queue_pkg::conv_state_t state;
  logic [7:0] wait_cnt;
  logic busy;
  assign busy = state != adc_queue_pkg::conv_idle;
  logic fifo_in_ready;
  logic fifo_in_valid;
  logic [15:0] fifo_in_data;
  logic can_start;
  // a scan needs a finished, non-empty list
  // an acquire during a conversion is dropped, not queued: one command, one sample
  assign can_start = cmd_acq && load_done && queue_len != '0 && !busy;
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state <= adc_queue_pkg::conv_idle;
    end else begin
      case (state)
        adc_queue_pkg::conv_idle: begin
          if (can_start) begin
            state <= adc_queue_pkg::conv_start;
          end
        end
        adc_queue_pkg::conv_start: begin
          state <= adc_queue_pkg::conv_wait;
        end
        adc_queue_pkg::conv_wait: begin
          // converter done edge, or a timeout so a dead converter cannot hang us
          if (done_rise || wait_cnt == `CONV_CYCLES) begin
            state <= adc_queue_pkg::conv_store;
          end
        end
        adc_queue_pkg::conv_store: begin
          // stall until the fifo has room: results are never dropped
          if (fifo_in_ready) begin
            state <= adc_queue_pkg::conv_idle;
          end
        end
        default: begin
          state <= adc_queue_pkg::conv_idle;
        end
      endcase
    end
  end
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wait_cnt <= 8'h00;
    end else if (state == adc_queue_pkg::conv_wait) begin
      wait_cnt <= wait_cnt + 8'h01;
    end else begin
      wait_cnt <= 8'h00;
    end
  end
  // latch result on the done edge; 16-bit straight binary passes unchanged
  // a timeout stores the previous result again; nothing flags it
  logic [15:0] result;
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      result <= `RESET_WORD;
    end else if (state == adc_queue_pkg::conv_wait && done_rise) begin
      result <= conv_data;
    end
  end
  assign fifo_in_valid = state == adc_queue_pkg::conv_store;
  assign fifo_in_data = result;
  // load done rewinds the scan, so every new list starts at its first entry
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      scan_ptr <= '0;
    end else if (cmd_qreset || cmd_done) begin
      scan_ptr <= '0;
    end else if (state == adc_queue_pkg::conv_store && fifo_in_ready) begin
      if ((QW+1)'(scan_ptr) + (QW+1)'(1) >= queue_len) begin
        scan_ptr <= '0;
      end else begin
        scan_ptr <= scan_ptr + QW'(1);
      end
    end
  end
  // front end selection driven from the current entry at conversion start
  adc_queue_pkg::queue_entry_t cur;
  assign cur = queue_mem[scan_ptr];
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mux_chan <= 6'h00;
      gain_sel <= 2'h0;
      unipolar <= 1'b0;
      diff_mode <= 1'b0;
      cm_ext_ref <= 1'b0;
    end else if (can_start) begin
      mux_chan <= cur.chan;
      gain_sel <= cur.range[1:0];
      unipolar <= cur.range[2];
      diff_mode <= cur.diff;
      // the reference choice only applies to single-ended inputs
      cm_ext_ref <= cur.cmref && !cur.diff;
    end
  end
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      conv_start_pulse <= 1'b0;
    end else begin
      conv_start_pulse <= can_start;
    end
  end

  // sample fifo, drained by reads of the sample register
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic sample_rd;
  assign sample_rd = reg_hit(reg_rd, reg_addr, `ADDR_SAMPLE);
  sample_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_sample_fifo (
    .core_clk(core_clk),
    .rst_sync_b(rst_sync_b),
    .clear(cmd_sclear),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(sample_rd),
    .out_data(fifo_out_data)
  );

  // read data, one cycle after the strobe
  // idle cycles read zero, so a stale word never looks like fresh data
  logic [15:0] status;
  always_comb begin
    status = 16'h0000;
    status[`STAT_DONE] = load_done;
    status[`STAT_BUSY] = busy;
    status[`STAT_READY] = fifo_out_valid;
    // full also reads high in a clear cycle, when the fifo takes nothing
    status[`STAT_FULL] = !fifo_in_ready;
    status[`STAT_BAD_ENTRY] = bad_entry;
    status[`STAT_QUEUE_EMPTY] = queue_len == '0;
  end
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_STATUS: reg_rdata <= status;
        `ADDR_SAMPLE: reg_rdata <= fifo_out_valid ? fifo_out_data : 16'h0000;
        `ADDR_QUEUE_COUNT: reg_rdata <= 16'(queue_len);
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule

// File: logic/adc_queue_pkg.sv
// types shared by the queue controller files
package adc_queue_pkg;
  typedef enum logic [1:0] {
    conv_idle = 2'b00,
    conv_start = 2'b01,
    conv_wait = 2'b10,
    conv_store = 2'b11
  } conv_state_t;
  typedef struct packed {
    logic cmref;
    logic diff;
    logic [2:0] range;
    logic [5:0] chan;
  } queue_entry_t;
endpackage

// File: logic/adc_queue_regs.svh
// register offsets, field positions and reset values of the queue controller
`ifndef ADC_QUEUE_REGS_SVH
`define ADC_QUEUE_REGS_SVH
`define ADDR_COMMAND 4'h0
`define ADDR_QUEUE_ENTRY 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_SAMPLE 4'h3
`define ADDR_QUEUE_COUNT 4'h4
`define CMD_QUEUE_RESET 0
`define CMD_QUEUE_LOAD_DONE 1
`define CMD_ACQUIRE 2
`define CMD_SAMPLE_CLEAR 3
`define ENT_CHAN_LSB 0
`define ENT_CHAN_MSB 5
`define ENT_RANGE_LSB 8
`define ENT_RANGE_MSB 10
`define ENT_DIFF 12
`define ENT_CMREF 13
`define STAT_DONE 0
`define STAT_BUSY 1
`define STAT_READY 2
`define STAT_FULL 3
`define STAT_BAD_ENTRY 4
`define STAT_QUEUE_EMPTY 5
`define CONV_CYCLES 8'h28
`define RESET_WORD 16'h0000
`endif

// File: logic/sample_fifo.sv
// sample fifo: parameterised width and depth, registered read data
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_sync_b,
  input wire logic clear,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready = (count != AW'(0) + (AW+1)'(DEPTH)) && !clear;
  assign push = in_valid && in_ready;
  // head is held in out_data, so a valid word exists once pulled out of mem
  assign pop = out_valid && out_ready;
  logic load_head;
  logic [AW:0] stored;
  assign stored = count - {{AW{1'b0}}, out_valid};
  assign load_head = (stored != '0) && (!out_valid || pop);
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wr_ptr <= '0;
    end else if (clear) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + AW'(1);
    end
  end
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rd_ptr <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (clear) begin
      rd_ptr <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (load_head) begin
      rd_ptr <= rd_ptr + AW'(1);
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end else if (pop) begin
      out_valid <= 1'b0;
    end
  end
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else begin
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
